// *** verilog/bcd_conv_map.svh ***
`ifndef BCD_CONV_MAP_SVH
`define BCD_CONV_MAP_SVH

// Digit width and adjustment constants.
`define DIGIT_W        4
`define ADJ_LIMIT      4'h5
`define ADJ_ADD        4'h3
`define DIGIT_ZERO     4'h0
// Default binary width and the number of digits it needs.
`define BIN_W_DEF      16
`define DIGITS_DEF     5
// Step of the shift chain and of the shift counter.
`define SHIFT_STEP     1
// Packing of five digits into three bytes.
`define BYTE_W         8
`define BYTE_ZERO      8'h00
`define UNITS_TENS_LSB 0
`define HUND_THOU_LSB  8
`define TEN_THOU_LSB   16

`endif

// *** verilog/bcd_conv_pkg.sv ***
`default_nettype none
package bcd_conv_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b10
  } conv_state_t;

endpackage : bcd_conv_pkg
`default_nettype wire

// *** verilog/digit_adjust.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "bcd_conv_map.svh"

module digit_adjust (
  // Digit before and after adjustment
  input  wire logic [`DIGIT_W-1:0] digit_in,
  output logic      [`DIGIT_W-1:0] digit_out
);

  always_comb begin
    if (digit_in >= `ADJ_LIMIT) begin
      digit_out = digit_in + `ADJ_ADD;
    end else begin
      digit_out = digit_in;
    end
  end

endmodule : digit_adjust
`default_nettype wire

// *** verilog/bin_to_bcd.sv ***
// Operation
// - Binary word held in shift register with enough 4-bit digit registers.
// - Before each shift every digit is checked for five or more.
// - Digits of five or more get three added; others unchanged.
// - Binary and digit registers shift left together as one chain.
// - Adjust and shift repeat exactly input-width times, then stop.
// - After the last shift the digits hold the decimal value.
// - Five-digit result packed as units/tens, hundreds/thousands, ten-thousands bytes.
`timescale 1ns/1ns
`default_nettype none
`include "bcd_conv_map.svh"

module bin_to_bcd #(
  parameter int BIN_W  = `BIN_W_DEF,
  parameter int DIGITS = `DIGITS_DEF
) (
  // Clock, reset and enable
  input  wire logic                  REF_CLK,
  input  wire logic                  RST_N,
  input  wire logic                  CLK_EN,
  // Request
  input  wire logic                  START,
  input  wire logic [BIN_W-1:0]      BIN_IN,
  // Answer
  output logic                       BUSY,
  output logic                       DONE,
  output logic [DIGITS*`DIGIT_W-1:0] BCD_OUT,
  output logic [7:0]                 UNITS_TENS_DIGITS,
  output logic [7:0]                 HUNDREDS_THOUSANDS_DIGITS,
  output logic [7:0]                 TEN_THOUSANDS_DIGIT
);

  // Each step lifts every digit of five or more by three, then shifts the digits and the binary word left
  // together. The lift makes a doubled digit carry into the next one exactly when it reaches ten, so after
  // BIN_W steps the binary word is empty and the digits hold its decimal value.

  // Sizes derived from the parameters.
  localparam int DW    = DIGITS * `DIGIT_W;
  localparam int CNT_W = $clog2(BIN_W + 1);

  // The last of the BIN_W shifts is made while the count shows BIN_W - 1.
  localparam logic [CNT_W-1:0] STEP      = CNT_W'(`SHIFT_STEP);
  localparam logic [CNT_W-1:0] SHIFTS    = CNT_W'(BIN_W);
  localparam logic [CNT_W-1:0] LAST_STEP = SHIFTS - STEP;

  // Conversion state.
  bcd_conv_pkg::conv_state_t state_reg;
  logic [BIN_W-1:0]          bin_reg;
  logic [DW-1:0]             digits_reg;
  logic [CNT_W-1:0]          count_reg;

  // Held results, which stand until the next conversion ends.
  logic [DW-1:0]             bcd_out_reg;
  logic [`BYTE_W-1:0]        units_tens_reg;
  logic [`BYTE_W-1:0]        hundreds_thousands_reg;
  logic [`BYTE_W-1:0]        ten_thousands_reg;

  // Adjust and shift chain.
  logic [DW-1:0]             adj_digits;
  logic [DW+BIN_W-1:0]       chain_next;
  logic [DW-1:0]             digits_next;
  logic [BIN_W-1:0]          bin_next;

  // Packed bytes as they will stand after the last step.
  logic [`BYTE_W-1:0]        units_tens_next;
  logic [`BYTE_W-1:0]        hundreds_thousands_next;
  logic [`BYTE_W-1:0]        ten_thousands_next;

  // Sequencing strobes.
  logic                      take;
  logic                      running;
  logic                      last_shift;

  // Every digit is checked and adjusted in parallel, ahead of the shift.
  genvar g;
  generate
    for (g = 0; g < DIGITS; g++) begin : g_adj
      digit_adjust u_adj (
        .digit_in  (digits_reg[g*`DIGIT_W +: `DIGIT_W]),
        .digit_out (adj_digits[g*`DIGIT_W +: `DIGIT_W])
      );
    end
  endgenerate

  // A start is taken only while idle; a request during a run or in the completion cycle is ignored.
  assign take       = (state_reg == bcd_conv_pkg::ST_IDLE) && START;
  assign running    = (state_reg == bcd_conv_pkg::ST_RUN);
  assign last_shift = running && (count_reg == LAST_STEP);

  // The top binary bit enters the units digit, and each digit's top bit enters the next digit up.
  assign chain_next  = {adj_digits, bin_reg} << `SHIFT_STEP;
  assign digits_next = chain_next[DW+BIN_W-1:BIN_W];
  assign bin_next    = chain_next[BIN_W-1:0];

  // Two digits to a byte, the lower digit in the low nibble; the top byte holds one digit.
  assign units_tens_next         = digits_next[`UNITS_TENS_LSB +: `BYTE_W];
  assign hundreds_thousands_next = digits_next[`HUND_THOU_LSB +: `BYTE_W];
  assign ten_thousands_next      = {`DIGIT_ZERO, digits_next[`TEN_THOU_LSB +: `DIGIT_W]};

  // Every register below moves only with CLK_EN high; reset acts regardless of it.

  // Sequencer: idle, shifting, then one cycle of completion.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state_reg <= bcd_conv_pkg::ST_IDLE;
    end else if (CLK_EN) begin
      case (state_reg)
        bcd_conv_pkg::ST_IDLE: begin
          if (take) begin
            state_reg <= bcd_conv_pkg::ST_RUN;
          end
        end
        bcd_conv_pkg::ST_RUN: begin
          if (last_shift) begin
            state_reg <= bcd_conv_pkg::ST_DONE;
          end
        end
        bcd_conv_pkg::ST_DONE: begin
          state_reg <= bcd_conv_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= bcd_conv_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Binary word: loaded on a start, then shifted out from the top.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      bin_reg <= '0;
    end else if (CLK_EN) begin
      if (take) begin
        bin_reg <= BIN_IN;
      end else if (running) begin
        bin_reg <= bin_next;
      end
    end
  end

  // Digits: cleared on a start, then adjusted and shifted once per step.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      digits_reg <= '0;
    end else if (CLK_EN) begin
      if (take) begin
        digits_reg <= '0;
      end else if (running) begin
        digits_reg <= digits_next;
      end
    end
  end

  // Step counter: its width leaves room for BIN_W, so it cannot wrap before the last step.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      count_reg <= '0;
    end else if (CLK_EN) begin
      if (take) begin
        count_reg <= '0;
      end else if (running) begin
        count_reg <= count_reg + STEP;
      end
    end
  end

  // The whole result is captured from the last step, so it appears together with DONE.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      bcd_out_reg <= '0;
    end else if (CLK_EN) begin
      if (last_shift) begin
        bcd_out_reg <= digits_next;
      end
    end
  end

  // Units with tens.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      units_tens_reg <= `BYTE_ZERO;
    end else if (CLK_EN) begin
      if (last_shift) begin
        units_tens_reg <= units_tens_next;
      end
    end
  end

  // Hundreds with thousands.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      hundreds_thousands_reg <= `BYTE_ZERO;
    end else if (CLK_EN) begin
      if (last_shift) begin
        hundreds_thousands_reg <= hundreds_thousands_next;
      end
    end
  end

  // Ten-thousands alone, with the upper nibble held at zero.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ten_thousands_reg <= `BYTE_ZERO;
    end else if (CLK_EN) begin
      if (last_shift) begin
        ten_thousands_reg <= ten_thousands_next;
      end
    end
  end

  // The byte outputs assume the default of five digits; other sizes should read BCD_OUT.
  assign BCD_OUT                   = bcd_out_reg;
  assign UNITS_TENS_DIGITS         = units_tens_reg;
  assign HUNDREDS_THOUSANDS_DIGITS = hundreds_thousands_reg;
  assign TEN_THOUSANDS_DIGIT       = ten_thousands_reg;

  // DONE lasts one enabled cycle and BUSY covers the whole run including it.
  assign BUSY = (state_reg != bcd_conv_pkg::ST_IDLE);
  assign DONE = (state_reg == bcd_conv_pkg::ST_DONE);

endmodule : bin_to_bcd
`default_nettype wire

// *** testbench/bin_to_bcd_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module bcd_chk (
  // Clock, reset and enable
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic        CLK_EN,
  // Handshake
  input wire logic        START,
  input wire logic        BUSY,
  input wire logic        DONE,
  // Result
  input wire logic [19:0] BCD_OUT,
  input wire logic [7:0]  UNITS_TENS_DIGITS,
  input wire logic [7:0]  HUNDREDS_THOUSANDS_DIGITS,
  input wire logic [7:0]  TEN_THOUSANDS_DIGIT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_take; START && !BUSY && CLK_EN; endsequence
  sequence s_full_run; s_take ##1 CLK_EN[*8] ##1 CLK_EN[*8]; endsequence
  a_take_busy: assert property (s_take |=> ##1 BUSY[*8]) else $error("busy gap");
  a_no_early: assert property (s_take |=> !DONE[*8]) else $error("early done");
  a_done_time: assert property (s_full_run |=> DONE) else $error("late done");
  a_done_pulse: assert property (DONE && CLK_EN |=> !DONE) else $error("long done");
  a_done_busy: assert property (DONE |-> BUSY) else $error("done idle");
  a_done_end: assert property (DONE && CLK_EN |=> !BUSY) else $error("busy stuck");
  a_busy_drop: assert property ($fell(BUSY) |-> $past(DONE)) else $error("busy drop");
  a_data_when: assert property ($changed(BCD_OUT) |-> DONE) else $error("data moved");
  a_freeze_hold: assert property (!CLK_EN |=> $stable(BUSY) && $stable(DONE) && $stable(BCD_OUT))
    else $error("moved while frozen");
  a_pack_bytes: assert property ({TEN_THOUSANDS_DIGIT, HUNDREDS_THOUSANDS_DIGITS, UNITS_TENS_DIGITS} == {4'h0, BCD_OUT})
    else $error("bytes differ");
endmodule : bcd_chk
bind bin_to_bcd bcd_chk u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN), .START(START), .BUSY(BUSY),
  .DONE(DONE), .BCD_OUT(BCD_OUT), .UNITS_TENS_DIGITS(UNITS_TENS_DIGITS),
  .HUNDREDS_THOUSANDS_DIGITS(HUNDREDS_THOUSANDS_DIGITS), .TEN_THOUSANDS_DIGIT(TEN_THOUSANDS_DIGIT));
`default_nettype wire

// *** testbench/bcd_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module bcd_host (input wire logic clk, output logic start, output logic [15:0] bin_in);
  initial {start, bin_in} = '0;
  // Outside a request the word shows the inverse of the last one, never a held value.
  task automatic go(input logic [15:0] v, input int late);
    repeat (late + 1) @(posedge clk);
    #2 {start, bin_in} = {1'b1, v};
    @(posedge clk);
    #2 {start, bin_in} = {1'b0, ~v};
  endtask : go
endmodule : bcd_host
`default_nettype wire

// *** testbench/binary_to_bcd_add3_converter_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module binary_to_bcd_add3_converter_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, start, busy, done;
  logic [15:0] bin_in;
  logic [19:0] bcd;
  logic [7:0] b0, b1, b2;
  int miscompares = 0, compares = 0, cycles = 0;
  always #10 clk = ~clk;
  bin_to_bcd u_dut (.REF_CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en), .START(start), .BIN_IN(bin_in), .BUSY(busy),
    .DONE(done), .BCD_OUT(bcd), .UNITS_TENS_DIGITS(b0), .HUNDREDS_THOUSANDS_DIGITS(b1), .TEN_THOUSANDS_DIGIT(b2));
  bcd_host u_host (.clk(clk), .start(start), .bin_in(bin_in));
  task automatic check(input logic [23:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    if (miscompares == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // Decimal digits of v, units in the low nibble, worked out by division.
  function automatic logic [23:0] exp_bcd(input int v);
    logic [23:0] e;
    e = '0;
    for (int i = 0; i < 5; i++) e[4*i+:4] = 4'((v / 10 ** i) % 10);
    return e;
  endfunction : exp_bcd
  // With poke set, a second request made while busy must leave the first result intact.
  task automatic t_conv(input int v, late, input bit poke);
    u_host.go(16'(v), late);
    if (poke) u_host.go(16'(~v), 3);
    repeat (poke ? 11 : 16) @(posedge clk);
    #2 check(24'({done, busy}), 24'h00_0003);
    check(24'(bcd), exp_bcd(v));
    check({b2, b1, b0}, exp_bcd(v));
    @(posedge clk);
    #2 check(24'({done, busy}), 24'h00_0000);
  endtask : t_conv
  // Dropping the clock enable for ten cycles mid-run must stall the shifts without losing any.
  task automatic t_freeze(input int v);
    u_host.go(16'(v), 0);
    repeat (4) @(posedge clk);
    #2 clk_en = 1'b0;
    repeat (10) @(posedge clk);
    #2 check(24'({done, busy}), 24'h00_0001);
    clk_en = 1'b1;
    repeat (12) @(posedge clk);
    #2 check(24'({done, busy}), 24'h00_0003);
    check(24'(bcd), exp_bcd(v));
  endtask : t_freeze
  always @(posedge clk) if (++cycles == 1000) begin
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clk);
    #2 rst_n = 1'b1;
    t_conv(0, 0, 0);
    t_conv(65535, 0, 1);
    t_conv(39999, 2, 0);
    t_conv(12345, 1, 1);
    t_freeze(54321);
    print_verdict();
  end
endmodule : binary_to_bcd_add3_converter_tb_top
`default_nettype wire
